// ### design/ckd_pkg.sv
// shared constants for the clock output divider
package ckd_pkg;
  localparam logic [1:0] DIV_SEL_QUARTER = 2'h0;
  localparam logic [1:0] DIV_SEL_HALF    = 2'h1;
  localparam logic [1:0] DIV_SEL_FULL    = 2'h2;
  localparam logic [1:0] DIV_SEL_OFF     = 2'h3;
  localparam logic [1:0] DIV_SEL_RESET   = DIV_SEL_QUARTER;
  localparam int         DIV_SEL_LSB     = 0;
  localparam int         DIV_SEL_MSB     = 1;
  localparam logic [1:0] PHASE_RESET     = 2'h0;
  localparam logic [1:0] PHASE_STEP      = 2'h1;
  localparam logic       PIN_RESET       = 1'b0;
  localparam logic       PIN_OE_RESET    = 1'b1;
endpackage : ckd_pkg

// ### design/ckd_phase_if.sv
// divider phase carried from the phase counter to the output stage
`timescale 1ns/1ps
interface ckd_phase_if;
  logic [1:0] phase;
  modport src (output phase);
  modport dst (input  phase);
endinterface : ckd_phase_if

// ### design/ckd_phase_counter.sv
// two-bit phase counter of the system clock, stepping only on cycles with clock enable high
`timescale 1ns/1ps
module ckd_phase_counter (
  input  wire logic  clk_sys_in,
  input  wire logic  sys_rst_in,
  input  wire logic  clk_en_in,
  ckd_phase_if.src   phase_if
);

  typedef struct packed {
    logic [1:0] phase;
  } ckd_cnt_state_type;

  ckd_cnt_state_type state_r;
  ckd_cnt_state_type state_nxt;

  always_comb begin
    state_nxt       = state_r;
    state_nxt.phase = 2'(state_r.phase + ckd_pkg::PHASE_STEP);
  end

  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      state_r.phase <= ckd_pkg::PHASE_RESET;
    end else if (clk_en_in) begin
      state_r <= state_nxt;
    end
  end

  assign phase_if.phase = state_r.phase;

endmodule // ckd_phase_counter

// ### design/ckd_clock_output_divider.sv
// external clock output divider with divide select and off setting
`timescale 1ns/1ps
// What this block does
// RULE_01: output clock at full, half, quarter rate
// RULE_02: reset selects quarter system clock rate
// RULE_03: select value 3 stops the output clock
// RULE_04: pin stays actively driven during reset
// RULE_05: codes 0 quarter, 1 half, 2 full
module ckd_clock_output_divider (
  input  wire logic       clk_sys_in,
  input  wire logic       sys_rst_in,
  input  wire logic       clk_en_in,
  input  wire logic       ctrl_wr_in,
  input  wire logic [1:0] ctrl_wdata_in,
  output logic      [1:0] clkout_divide_select_out,
  output logic            external_clock_output_out,
  output logic            external_clock_output_oe_out
);

  typedef struct packed {
    logic [1:0] clkout_divide_select;
    logic       pin;
    logic       pin_oe;
    logic       full_rate;
  } ckd_state_type;

  ckd_state_type state_r;
  ckd_state_type state_nxt;

  ckd_phase_if phase_bus ();

  ckd_phase_counter u_phase (
    .clk_sys_in (clk_sys_in),
    .sys_rst_in (sys_rst_in),
    .clk_en_in  (clk_en_in),
    .phase_if   (phase_bus)
  );

  // clock_output_control_reg is held here; the select field is its bits 1:0
  always_comb begin
    state_nxt           = state_r;
    state_nxt.pin_oe    = ckd_pkg::PIN_OE_RESET; // RULE_04
    state_nxt.full_rate = 1'b0;
    if (ctrl_wr_in) begin
      state_nxt.clkout_divide_select = ctrl_wdata_in[ckd_pkg::DIV_SEL_MSB:ckd_pkg::DIV_SEL_LSB]; // RULE_01
    end
    case (state_r.clkout_divide_select)
      ckd_pkg::DIV_SEL_QUARTER: begin
        state_nxt.pin = phase_bus.phase[1]; // RULE_05
      end
      ckd_pkg::DIV_SEL_HALF: begin
        state_nxt.pin = phase_bus.phase[0]; // RULE_05
      end
      ckd_pkg::DIV_SEL_FULL: begin
        state_nxt.pin       = 1'b0;
        state_nxt.full_rate = 1'b1; // RULE_05
      end
      default: begin
        // parked low rather than left at a random level
        state_nxt.pin = 1'b0; // RULE_03
      end
    endcase
  end

  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      state_r.clkout_divide_select <= ckd_pkg::DIV_SEL_RESET; // RULE_02
      state_r.pin                  <= ckd_pkg::PIN_RESET;
      state_r.pin_oe               <= ckd_pkg::PIN_OE_RESET; // RULE_04
      state_r.full_rate            <= 1'b0;
    end else if (clk_en_in) begin
      state_r <= state_nxt;
    end
  end

  assign clkout_divide_select_out     = state_r.clkout_divide_select;
  assign external_clock_output_oe_out = state_r.pin_oe;
  // full rate cannot come from a flop; the clock is passed through, gated by a
  // registered select, so a glitch is possible only on the switch cycle
  assign external_clock_output_out    = state_r.full_rate ? clk_sys_in : state_r.pin; // RULE_01

  property p_half_toggles;
    @(posedge clk_sys_in) disable iff (sys_rst_in)
    (state_r.clkout_divide_select == ckd_pkg::DIV_SEL_HALF && clk_en_in && !ctrl_wr_in) ##1
    (state_r.clkout_divide_select == ckd_pkg::DIV_SEL_HALF && clk_en_in)
    |=> state_r.pin != $past(state_r.pin);
  endproperty
  a_half_toggles: assert property (p_half_toggles) else $error("half rate output did not toggle"); // RULE_01

  property p_reset_quarter;
    @(posedge clk_sys_in) disable iff (1'b0)
    $past(sys_rst_in) |-> state_r.clkout_divide_select == ckd_pkg::DIV_SEL_QUARTER && !state_r.full_rate;
  endproperty
  a_reset_quarter: assert property (p_reset_quarter) else $error("reset did not select quarter rate"); // RULE_02

  property p_off_low;
    @(posedge clk_sys_in) disable iff (sys_rst_in)
    (state_r.clkout_divide_select == ckd_pkg::DIV_SEL_OFF && clk_en_in)
    |=> external_clock_output_out == 1'b0 && !state_r.full_rate;
  endproperty
  a_off_low: assert property (p_off_low) else $error("output clock not stopped when off"); // RULE_03

  property p_driven_in_reset;
    @(posedge clk_sys_in) disable iff (1'b0)
    sys_rst_in |=> external_clock_output_oe_out;
  endproperty
  a_driven_in_reset: assert property (p_driven_in_reset) else $error("output pin released during reset"); // RULE_04

  property p_quarter_period;
    @(posedge clk_sys_in) disable iff (sys_rst_in)
    (state_r.clkout_divide_select == ckd_pkg::DIV_SEL_QUARTER && clk_en_in && !ctrl_wr_in)[*3]
    |=> state_r.pin != $past(state_r.pin, 2);
  endproperty
  a_quarter_period: assert property (p_quarter_period) else $error("quarter rate period wrong"); // RULE_05

  property p_full_select;
    @(posedge clk_sys_in) disable iff (sys_rst_in)
    (state_r.clkout_divide_select == ckd_pkg::DIV_SEL_FULL && clk_en_in) |=> state_r.full_rate;
  endproperty
  a_full_select: assert property (p_full_select) else $error("full rate not selected"); // RULE_05

  // a write is taken only on an enabled edge and shows on the select output one cycle later
  property p_write_takes;
    @(posedge clk_sys_in) disable iff (sys_rst_in)
    (ctrl_wr_in && clk_en_in) |=> clkout_divide_select_out == $past(ctrl_wdata_in);
  endproperty
  a_write_takes: assert property (p_write_takes) else $error("divide select write not taken"); // RULE_01

  property p_select_holds;
    @(posedge clk_sys_in) disable iff (sys_rst_in)
    !ctrl_wr_in |=> $stable(clkout_divide_select_out);
  endproperty
  a_select_holds: assert property (p_select_holds) else $error("divide select changed without write"); // RULE_01

  // clock enable low must freeze select, pin and phase alike
  property p_frozen_select;
    @(posedge clk_sys_in) disable iff (sys_rst_in)
    !clk_en_in |=> $stable(clkout_divide_select_out);
  endproperty
  a_frozen_select: assert property (p_frozen_select) else $error("select moved while frozen"); // RULE_01

  property p_frozen_pin;
    @(posedge clk_sys_in) disable iff (sys_rst_in)
    !clk_en_in |=> $stable(state_r.pin) && $stable(state_r.full_rate);
  endproperty
  a_frozen_pin: assert property (p_frozen_pin) else $error("pin state moved while frozen"); // RULE_01

  property p_frozen_phase;
    @(posedge clk_sys_in) disable iff (sys_rst_in)
    !clk_en_in |=> $stable(phase_bus.phase);
  endproperty
  a_frozen_phase: assert property (p_frozen_phase) else $error("phase moved while frozen"); // RULE_01

  property p_phase_steps;
    @(posedge clk_sys_in) disable iff (sys_rst_in)
    clk_en_in |=> phase_bus.phase == 2'($past(phase_bus.phase) + ckd_pkg::PHASE_STEP);
  endproperty
  a_phase_steps: assert property (p_phase_steps) else $error("phase counter did not step"); // RULE_01

  // divided modes: the pin copies one phase bit, one cycle late
  property p_follows_quarter;
    @(posedge clk_sys_in) disable iff (sys_rst_in)
    (state_r.clkout_divide_select == ckd_pkg::DIV_SEL_QUARTER && clk_en_in)
    |=> state_r.pin == $past(phase_bus.phase[1]);
  endproperty
  a_follows_quarter: assert property (p_follows_quarter) else $error("quarter pin not from phase"); // RULE_05

  property p_follows_half;
    @(posedge clk_sys_in) disable iff (sys_rst_in)
    (state_r.clkout_divide_select == ckd_pkg::DIV_SEL_HALF && clk_en_in)
    |=> state_r.pin == $past(phase_bus.phase[0]);
  endproperty
  a_follows_half: assert property (p_follows_half) else $error("half pin not from phase"); // RULE_05

  property p_half_period;
    @(posedge clk_sys_in) disable iff (sys_rst_in)
    (state_r.clkout_divide_select == ckd_pkg::DIV_SEL_HALF && clk_en_in && !ctrl_wr_in)[*3]
    |=> state_r.pin == $past(state_r.pin, 2);
  endproperty
  a_half_period: assert property (p_half_period) else $error("half rate period wrong"); // RULE_01

  // full rate: sampled on each edge the pin must show the clock level just before it
  property p_full_high;
    @(negedge clk_sys_in) disable iff (sys_rst_in)
    state_r.full_rate |-> external_clock_output_out;
  endproperty
  a_full_high: assert property (p_full_high) else $error("full rate output not high"); // RULE_01

  property p_full_low;
    @(posedge clk_sys_in) disable iff (sys_rst_in)
    state_r.full_rate |-> !external_clock_output_out;
  endproperty
  a_full_low: assert property (p_full_low) else $error("full rate output not low"); // RULE_01

  property p_full_entry;
    @(posedge clk_sys_in) disable iff (sys_rst_in)
    (ctrl_wr_in && clk_en_in && ctrl_wdata_in == ckd_pkg::DIV_SEL_FULL) ##1 clk_en_in
    |=> state_r.full_rate;
  endproperty
  a_full_entry: assert property (p_full_entry) else $error("full rate not entered after write"); // RULE_05

  property p_full_exit;
    @(posedge clk_sys_in) disable iff (sys_rst_in)
    (state_r.full_rate && state_r.clkout_divide_select != ckd_pkg::DIV_SEL_FULL && clk_en_in)
    |=> !state_r.full_rate;
  endproperty
  a_full_exit: assert property (p_full_exit) else $error("full rate not left"); // RULE_01

  property p_not_full;
    @(posedge clk_sys_in) disable iff (sys_rst_in)
    (state_r.clkout_divide_select != ckd_pkg::DIV_SEL_FULL && clk_en_in) |=> !state_r.full_rate;
  endproperty
  a_not_full: assert property (p_not_full) else $error("full rate set in other mode"); // RULE_05

  property p_off_entry;
    @(posedge clk_sys_in) disable iff (sys_rst_in)
    (ctrl_wr_in && clk_en_in && ctrl_wdata_in == ckd_pkg::DIV_SEL_OFF) ##1 clk_en_in
    |=> state_r.pin == 1'b0 && !state_r.full_rate;
  endproperty
  a_off_entry: assert property (p_off_entry) else $error("output not parked after off write"); // RULE_03

  // the pin must never float: enable high and a defined level from the first reset edge on
  property p_oe_after_reset;
    @(posedge clk_sys_in) disable iff (1'b0)
    !sys_rst_in |-> external_clock_output_oe_out;
  endproperty
  a_oe_after_reset: assert property (p_oe_after_reset) else $error("output pin not driven"); // RULE_04

  property p_pin_low_in_reset;
    @(posedge clk_sys_in) disable iff (1'b0)
    sys_rst_in |=> !external_clock_output_out;
  endproperty
  a_pin_low_in_reset: assert property (p_pin_low_in_reset) else $error("output pin level undefined in reset"); // RULE_04

endmodule // ckd_clock_output_divider

// ### sim/ckd_board_model.sv
// board load that counts rising edges of the external clock output
`timescale 1ns/1ps
module ckd_board_model (
  input  wire logic clr_in,
  input  wire logic pin_in,
  output int        edges_out
);
  // counts on the pin itself, since full rate is faster than any sampling flop
  always @(posedge pin_in or posedge clr_in) edges_out <= clr_in ? 0 : edges_out + 1;
endmodule // ckd_board_model

// ### sim/ckd_clock_output_divider_tb.sv
// self-checking bench of the clock output divider
`timescale 1ns/1ps
module ckd_clock_output_divider_tb;
  logic       clk = 1'b0, rst = 1'b1, en = 1'b1, wr = 1'b0, clr = 1'b1;
  logic [1:0] wd = 2'h0, sel;
  logic       pin, oe;
  int         edges, miscompares = 0, check_count = 0;
  always #10 clk = ~clk;
  ckd_clock_output_divider i_dut (.clk_sys_in(clk), .sys_rst_in(rst), .clk_en_in(en), .ctrl_wr_in(wr),
    .ctrl_wdata_in(wd), .clkout_divide_select_out(sel), .external_clock_output_out(pin),
    .external_clock_output_oe_out(oe));
  ckd_board_model i_board (.clr_in(clr), .pin_in(pin), .edges_out(edges));
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value %s expected %0h seen %0h", what, exp, got);
    end
  endtask
  task automatic write(input logic [1:0] v);
    wr = 1'b1;
    wd = v;
    step(1);
    wr = 1'b0;
    // one idle edge so that the next write never re-raises the strobe in this time step
    step(1);
  endtask
  // settle into the mode, then count pin edges over sixteen system cycles
  task automatic measure(input int exp);
    step(3);
    clr = 1'b1;
    #1 clr = 1'b0;
    step(16);
    chk("edges", exp, edges);
  endtask
  task automatic t_reset;
    rst = 1'b1;
    step(3);
    chk("oe in reset", 1, oe);
    chk("select in reset", ckd_pkg::DIV_SEL_RESET, sel);
    step(3);
    rst = 1'b0;
    measure(4);
  endtask
  task automatic t_modes;
    write(ckd_pkg::DIV_SEL_HALF);
    measure(8);
    write(ckd_pkg::DIV_SEL_OFF);
    write(ckd_pkg::DIV_SEL_FULL);
    chk("select", ckd_pkg::DIV_SEL_FULL, sel);
    measure(16);
    write(ckd_pkg::DIV_SEL_OFF);
    measure(0);
    chk("oe", 1, oe);
  endtask
  task automatic t_frozen;
    en = 1'b0;
    write(ckd_pkg::DIV_SEL_HALF);
    en = 1'b1;
    step(1);
    chk("select frozen", ckd_pkg::DIV_SEL_OFF, sel);
  endtask
  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    step(0);
    t_reset();
    t_modes();
    t_frozen();
    t_reset();
    give_verdict();
  end
endmodule // ckd_clock_output_divider_tb
